// >>> tb/uart_mp_partner.sv
`timescale 1ns/1ps
// far-side uart: drives our receive pin and listens to our transmit pin
module uart_mp_partner #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input wire logic clk_i,
    // serial line
    input wire logic line_i,
    output logic line_o
);
    // the wire idles high, as a pulled-up uart line does
    initial line_o = 1'b1;

    task automatic send(input logic [7:0] d, input logic nine, input logic ninth,
                        input logic stop);
        logic [10:0] f;
        int n;
        f = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
        n = nine ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask

    // sample each bit at its centre
    task automatic recv(input logic nine, output logic [7:0] d, output logic n9,
                        output logic st, output logic ok);
        int w;
        w = 0;
        d = 8'h00;
        n9 = 1'b0;
        while (line_i !== 1'b0 && w < 4000) begin
            @(posedge clk_i);
            w++;
        end
        ok = (w < 4000);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            d[i] = line_i;
        end
        if (nine) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            n9 = line_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        st = line_i;
    endtask
endmodule

// >>> tb/uart_multiproc_serial_port_tb.sv
`timescale 1ns/1ps
module uart_multiproc_serial_port_tb import uart_mp_pkg::*;;
    logic clk;
    logic rst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic ack;
    logic rx_line;
    logic tx_line;
    logic irq;
    logic [31:0] rdata;
    logic [7:0] pd;
    logic p9;
    logic pst;
    logic pok;
    int failures;
    int cmp_count;

    // device under test
    uart_mp_serial_port uart_mp_serial_port_inst (
        .CLK_I(clk),
        .RST_N_I(rst_n),
        .WB_CYC_I(cyc),
        .WB_STB_I(stb),
        .WB_WE_I(we),
        .WB_ADR_I(adr),
        .WB_SEL_I(sel),
        .WB_DAT_I(dat_w),
        .WB_DAT_O(dat_r),
        .WB_ACK_O(ack),
        .SERIAL_RX_PIN_I(rx_line),
        .SERIAL_TX_PIN_O(tx_line),
        .IRQ_O(irq)
    );

    // far side; baud divider is set to 0 so one bit is 16 clocks
    uart_mp_partner #(.BIT_CLKS(16)) uart_mp_partner_inst (
        .clk_i(clk),
        .line_i(tx_line),
        .line_o(rx_line)
    );

    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // one classic wishbone cycle; read data kept in rdata
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rdata = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            chk("wb_ack", 1, 0);
            end_of_test();
        end
        @(posedge clk);
    endtask

    // receive flag shows through the interrupt; bounded wait
    task automatic rx_wait();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("irq_rx", 1, irq);
        if (n >= 2000) begin
            end_of_test();
        end
    endtask

    task automatic t_reset();
        wb(0, CTRL_OFS, 0);
        chk("ctrl", 0, rdata);
        wb(0, STATUS_OFS, 0);
        chk("status", 0, rdata);
        wb(0, MASK_OFS, 0);
        chk("mask", {30'h0, MASK_RESET}, rdata);
        wb(0, BAUD_OFS, 0);
        chk("baud", {16'h0, BAUD_RESET}, rdata);
        wb(1, CTRL_OFS, 32'h40);
        wb(0, CTRL_OFS, 0);
        chk("ctrl_rsvd", 0, rdata);
        wb(0, 5'h14, 0);
        chk("unmapped", 0, rdata);
        chk("tx_idle", 1, tx_line);
        chk("irq_idle", 0, irq);
        // divider 1 gives 32 clocks a bit: start still low past 16 clocks
        wb(1, BAUD_OFS, 1);
        wb(1, DATA_OFS, 32'hFF);
        repeat (20) @(posedge clk);
        chk("baud_start", 0, tx_line);
        repeat (16) @(posedge clk);
        chk("baud_d0", 1, tx_line);
        repeat (300) @(posedge clk);
        wb(1, STATUS_OFS, 32'h2);
        wb(1, BAUD_OFS, 0);
    endtask

    // shared transmit frame; tx_done must appear as the stop bit starts
    task automatic tx_frame(input logic nine, input logic ninth, input logic [7:0] d);
        int bits;
        bits = nine ? 10 : 9;
        wb(1, CTRL_OFS, {24'h0, nine, 3'h0, ninth, 3'h0});
        wb(1, MASK_OFS, 32'h2);
        fork
            uart_mp_partner_inst.recv(nine, pd, p9, pst, pok);
            begin
                wb(1, DATA_OFS, {24'h0, d});
                // a byte written while busy is ignored, so the frame keeps d
                wb(1, DATA_OFS, {24'h0, ~d});
                repeat (bits * 16 - 9) @(posedge clk);
                chk("irq_pre_stop", 0, irq);
                repeat (8) @(posedge clk);
                chk("irq_at_stop", 1, irq);
                wb(0, DATA_OFS, 0);
                chk("tx_busy", 1, rdata[8]);
            end
        join
        chk("tx_data", d, pd);
        chk("tx_ninth", nine & ninth, p9);
        chk("tx_stop", 1, pst);
        chk("tx_frame", 1, pok);
        repeat (16) @(posedge clk);
    endtask

    task automatic t_tx8();
        tx_frame(0, 0, 8'hA5);
        repeat (40) @(posedge clk);
        wb(0, STATUS_OFS, 0);
        chk("tx_sticky", 32'h2, rdata);
        wb(1, STATUS_OFS, 32'h2);
        chk("irq_cleared", 0, irq);
    endtask

    task automatic t_tx9();
        tx_frame(1, 1, 8'h3C);
        wb(1, STATUS_OFS, 32'h2);
        tx_frame(1, 0, 8'hC3);
        wb(1, STATUS_OFS, 32'h2);
    endtask

    task automatic t_rx8();
        wb(1, CTRL_OFS, 32'h10);
        wb(1, MASK_OFS, 32'h1);
        uart_mp_partner_inst.send(8'h5A, 0, 0, 1);
        rx_wait();
        wb(0, DATA_OFS, 0);
        chk("rx_data", 32'h5A, rdata);
        wb(0, CTRL_OFS, 0);
        chk("rx_ctrl", 32'h15, rdata);
        uart_mp_partner_inst.send(8'h33, 0, 0, 1);
        repeat (8) @(posedge clk);
        wb(0, DATA_OFS, 0);
        chk("rx_overrun", 32'h5A, rdata);
        wb(1, MASK_OFS, 0);
        chk("irq_masked", 0, irq);
        wb(1, STATUS_OFS, 32'h1);
        wb(0, STATUS_OFS, 0);
        chk("rx_clear", 0, rdata);
    endtask

    task automatic t_rx_off();
        wb(1, CTRL_OFS, 0);
        uart_mp_partner_inst.send(8'h66, 0, 0, 1);
        repeat (8) @(posedge clk);
        wb(0, STATUS_OFS, 0);
        chk("rx_off", 0, rdata);
    endtask

    task automatic t_mproc();
        wb(1, MASK_OFS, 32'h1);
        wb(1, CTRL_OFS, 32'hB0);
        uart_mp_partner_inst.send(8'h11, 1, 0, 1);
        repeat (8) @(posedge clk);
        wb(0, STATUS_OFS, 0);
        chk("mp_data_skip", 0, rdata);
        uart_mp_partner_inst.send(8'h42, 1, 1, 1);
        rx_wait();
        wb(0, DATA_OFS, 0);
        chk("mp_addr", 32'h42, rdata);
        wb(0, CTRL_OFS, 0);
        chk("mp_ctrl", 32'hB5, rdata);
        wb(1, STATUS_OFS, 32'h1);
        // address matched: software drops multiprocessor filtering
        wb(1, CTRL_OFS, 32'h90);
        uart_mp_partner_inst.send(8'h77, 1, 0, 1);
        rx_wait();
        wb(0, DATA_OFS, 0);
        chk("mp_payload", 32'h77, rdata);
        wb(0, CTRL_OFS, 0);
        chk("mp_ninth0", 32'h91, rdata);
        wb(1, STATUS_OFS, 32'h1);
        wb(1, CTRL_OFS, 32'h30);
        uart_mp_partner_inst.send(8'h99, 0, 0, 0);
        repeat (8) @(posedge clk);
        wb(0, STATUS_OFS, 0);
        chk("mp_stop0", 0, rdata);
        uart_mp_partner_inst.send(8'h99, 0, 0, 1);
        rx_wait();
        wb(0, CTRL_OFS, 0);
        chk("mp_stop1", 32'h35, rdata);
    endtask

    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        sel = 4'hF;
        dat_w = 32'h0;
        failures = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_tx8();
        t_tx9();
        t_rx8();
        t_rx_off();
        t_mproc();
        end_of_test();
    end
endmodule

// >>> verilog/uart_mp_pkg.sv
package uart_mp_pkg;

    // register byte offsets on the wishbone slave
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] STATUS_OFS = 5'h04;
    localparam logic [4:0] MASK_OFS = 5'h08;
    localparam logic [4:0] BAUD_OFS = 5'h0C;
    localparam logic [4:0] DATA_OFS = 5'h10;

    // bit positions inside the status and mask registers
    localparam int RX_DONE_BIT = 0;
    localparam int TX_DONE_BIT = 1;

    // reset values
    localparam logic [15:0] BAUD_RESET = 16'h0036;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // oversampling: sixteen baud ticks per bit, centre at the eighth
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] RX_MID = 4'h7;

    // bits still to send after the start bit (data, optional ninth, stop)
    localparam logic [3:0] TX_BITS_8 = 4'h9;
    localparam logic [3:0] TX_BITS_9 = 4'hA;
    localparam logic [3:0] TX_STOP_LEFT = 4'h1;

    // index of the last data bit sampled by the receiver
    localparam logic [3:0] RX_LAST_8 = 4'h7;
    localparam logic [3:0] RX_LAST_9 = 4'h8;

    // control register layout, bit 7 down to bit 0; flag bits read only
    typedef struct packed {
        logic frame_mode_select;
        logic rsvd6;
        logic multiproc_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } ctrl_t;

    // one received character as handed from the receiver
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stop;
    } rx_char_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// >>> verilog/uart_mp_rx.sv
`timescale 1ns/1ps
module uart_mp_rx import uart_mp_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // timing, control and synchronised line
    input wire logic tick_i,
    input wire logic enable_i,
    input wire logic nine_i,
    input wire logic rx_i,
    // received character
    output logic valid_o,
    output rx_char_t char_o
);
    rx_state_t state_reg;
    logic [3:0] os_reg;
    logic [3:0] idx_reg;
    logic [8:0] shift_reg;
    logic prev_reg;
    logic valid_reg;
    rx_char_t char_reg;

    wire centre = tick_i & (os_reg == OS_LAST);
    wire [3:0] last_idx = nine_i ? RX_LAST_9 : RX_LAST_8;

    // falling edge, then sample at mid bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= RX_IDLE;
            os_reg <= 4'h0;
            idx_reg <= 4'h0;
            shift_reg <= 9'h000;
            prev_reg <= 1'b1;
            valid_reg <= 1'b0;
            char_reg <= '0;
        end else begin
            prev_reg <= rx_i;
            valid_reg <= 1'b0;
            if (tick_i) begin
                os_reg <= os_reg + 4'h1;
            end
            if (!enable_i) begin
                state_reg <= RX_IDLE;
            end else begin
                case (state_reg)
                    RX_IDLE: begin
                        if (prev_reg && !rx_i) begin
                            state_reg <= RX_START;
                            os_reg <= 4'h0;
                        end
                    end
                    RX_START: begin
                        // a glitch shorter than half a bit is dropped
                        if (tick_i && os_reg == RX_MID) begin
                            state_reg <= rx_i ? RX_IDLE : RX_DATA;
                            os_reg <= 4'h0;
                            idx_reg <= 4'h0;
                        end
                    end
                    RX_DATA: begin
                        if (centre) begin
                            shift_reg <= {rx_i, shift_reg[8:1]};
                            idx_reg <= idx_reg + 4'h1;
                            if (idx_reg == last_idx) begin
                                state_reg <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (centre) begin
                            char_reg.data <= nine_i ? shift_reg[7:0] : shift_reg[8:1];
                            char_reg.ninth <= nine_i ? shift_reg[8] : rx_i;
                            char_reg.stop <= rx_i;
                            valid_reg <= 1'b1;
                            state_reg <= RX_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    assign valid_o = valid_reg;
    assign char_o = char_reg;
endmodule

// >>> verilog/uart_mp_serial_port.sv
// Operation
// - one control bit picks 8-bit or 9-bit framing both ways
// - 8-bit frame is start, eight data bits lsb first, stop
// - accepted character loads buffer; ninth bit, or stop bit in 8-bit mode, copied into received ninth flag
// - writing the data register while the transmitter is idle starts transmission of that byte
// - transmit done flag sets as the stop bit begins
// - receiver works only while receive enable is one
// - accept only with receive flag clear and, under multiproc, bit one
// - on overrun the buffer keeps the first unread byte
// - rejected character changes nothing; accepted one sets receive flag
// - interrupt when an enabled transmit or receive flag is set
// - multiproc mode flags only characters whose ninth bit, or stop bit in 8-bit mode, is one
`timescale 1ns/1ps
module uart_mp_serial_port import uart_mp_pkg::*; (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // serial line
    input wire logic SERIAL_RX_PIN_I,
    output logic SERIAL_TX_PIN_O,
    // interrupt
    output logic IRQ_O
);
    // byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ctrl_t ctrl_reg;
    ctrl_t ctrl_view;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;
    logic [15:0] baud_reg;
    logic [15:0] baud_cnt_reg;
    logic tick_reg;
    logic [7:0] rx_buf_reg;
    logic rx_ninth_reg;
    logic [1:0] rx_sync_reg;
    logic ack_reg;
    logic [31:0] dat_o_reg;
    logic [31:0] rd_word;

    // bus decode
    wire bus_req = WB_CYC_I & WB_STB_I;
    wire wr_fire = bus_req & WB_WE_I & ack_reg;
    wire hit_ctrl = (WB_ADR_I == CTRL_OFS);
    wire hit_status = (WB_ADR_I == STATUS_OFS);
    wire hit_mask = (WB_ADR_I == MASK_OFS);
    wire hit_baud = (WB_ADR_I == BAUD_OFS);
    wire hit_data = (WB_ADR_I == DATA_OFS);

    // merged write words for the byte-lane registers
    wire [31:0] ctrl_wr = lane_merge({24'h000000, ctrl_view}, WB_DAT_I, WB_SEL_I);
    wire [31:0] mask_wr = lane_merge({30'h00000000, mask_reg}, WB_DAT_I, WB_SEL_I);
    wire [31:0] baud_wr = lane_merge({16'h0000, baud_reg}, WB_DAT_I, WB_SEL_I);

    // receiver and transmitter links
    wire rx_line = rx_sync_reg[1];
    wire rx_valid;
    rx_char_t rx_char;
    wire tx_busy;
    wire tx_done_pulse;

    // a data write loads the transmitter
    wire tx_start = wr_fire & hit_data & WB_SEL_I[0];

    // the bit that multiproc mode checks is the ninth or the stop bit
    // ninth bit zero is dropped while multiproc is set
    wire gate_bit = ctrl_reg.frame_mode_select ? rx_char.ninth : rx_char.stop;
    wire rx_accept = rx_valid & ~status_reg[RX_DONE_BIT] &
                     (~ctrl_reg.multiproc_enable | gate_bit);

    // write-one-to-clear; a hardware set in the same cycle wins
    wire [1:0] clr_bits = (wr_fire & hit_status & WB_SEL_I[0]) ? WB_DAT_I[1:0] : 2'h0;
    wire [1:0] set_bits = {tx_done_pulse, rx_accept};

    assign status_next = (status_reg & ~clr_bits) | set_bits;

    // control register view with read-only status mirrored in
    always_comb begin
        ctrl_view = ctrl_reg;
        ctrl_view.rsvd6 = 1'b0;
        ctrl_view.rx_ninth_bit = rx_ninth_reg;
        ctrl_view.tx_done_flag = status_reg[TX_DONE_BIT];
        ctrl_view.rx_done_flag = status_reg[RX_DONE_BIT];
    end

    // read mux; unmapped offsets answer with zero
    always_comb begin
        rd_word = 32'h00000000;
        case (1'b1)
            hit_ctrl: rd_word = {24'h000000, ctrl_view};
            hit_status: rd_word = {30'h00000000, status_reg};
            hit_mask: rd_word = {30'h00000000, mask_reg};
            hit_baud: rd_word = {16'h0000, baud_reg};
            hit_data: rd_word = {23'h000000, tx_busy, rx_buf_reg};
            default: rd_word = 32'h00000000;
        endcase
    end

    // single wait state: ack one cycle after the request, dropped after one
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_reg <= 1'b0;
            dat_o_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req && !ack_reg) begin
                dat_o_reg <= rd_word;
            end
        end
    end

    // mode bit steers both directions
    // control, mask and baud registers
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_reg <= '0;
            mask_reg <= MASK_RESET;
            baud_reg <= BAUD_RESET;
        end else if (wr_fire) begin
            if (hit_ctrl) begin
                ctrl_reg.frame_mode_select <= ctrl_wr[7];
                ctrl_reg.multiproc_enable <= ctrl_wr[5];
                ctrl_reg.rx_enable <= ctrl_wr[4];
                ctrl_reg.tx_ninth_bit <= ctrl_wr[3];
            end
            if (hit_mask) begin
                mask_reg <= mask_wr[1:0];
            end
            if (hit_baud) begin
                baud_reg <= baud_wr[15:0];
            end
        end
    end

    // baud tick at sixteen times the bit rate
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            baud_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (baud_cnt_reg == baud_reg);
            baud_cnt_reg <= (baud_cnt_reg >= baud_reg) ? 16'h0000 : baud_cnt_reg + 16'h0001;
        end
    end

    // line input is asynchronous, so two flops before the receiver
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rx_sync_reg <= 2'h3;
        end else begin
            rx_sync_reg <= {rx_sync_reg[0], SERIAL_RX_PIN_I};
        end
    end

    // receive flag set and buffer loaded only on acceptance
    // overrun leaves the unread byte in place
    // data to buffer, checked bit to received ninth flag
    // ninth bit, or stop bit in 8-bit mode, kept in the received ninth flag
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            status_reg <= 2'h0;
            rx_buf_reg <= 8'h00;
            rx_ninth_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (rx_accept) begin
                rx_buf_reg <= rx_char.data;
                rx_ninth_reg <= gate_bit;
            end
        end
    end

    assign IRQ_O = |(status_reg & mask_reg);
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_o_reg;

    // transmitter
    uart_mp_tx uart_mp_tx_inst (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .tick_i(tick_reg),
        .start_i(tx_start),
        .data_i(WB_DAT_I[7:0]),
        .nine_i(ctrl_reg.frame_mode_select),
        .ninth_i(ctrl_reg.tx_ninth_bit),
        .tx_o(SERIAL_TX_PIN_O),
        .busy_o(tx_busy),
        .done_o(tx_done_pulse)
    );

    // receiver
    uart_mp_rx uart_mp_rx_inst (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .tick_i(tick_reg),
        .enable_i(ctrl_reg.rx_enable),
        .nine_i(ctrl_reg.frame_mode_select),
        .rx_i(rx_line),
        .valid_o(rx_valid),
        .char_o(rx_char)
    );

    // assertion helpers: clocks spent busy and the framing latched at the
    // write, since software may change the mode while a frame is going out
    logic [8:0] tx_span_reg;
    logic tx_nine_reg;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_span_reg <= 9'h000;
            tx_nine_reg <= 1'b0;
        end else if (tx_start && !tx_busy) begin
            tx_span_reg <= 9'h000;
            tx_nine_reg <= ctrl_reg.frame_mode_select;
        end else if (tx_busy) begin
            tx_span_reg <= tx_span_reg + 9'h001;
        end
    end

    // busy length with a tick on every clock: frame bits times sixteen
    wire [8:0] span_8 = {1'b0, TX_BITS_8 + 4'h1, 4'h0};
    wire [8:0] span_9 = {1'b0, TX_BITS_9 + 4'h1, 4'h0};

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_tx_load;
        tx_start && !tx_busy;
    endsequence

    sequence s_rx_clean_reject;
        rx_valid && !status_reg[RX_DONE_BIT] && ctrl_reg.multiproc_enable && !gate_bit;
    endsequence

    a_tx_start_bit: assert property (
        s_tx_load |=> !SERIAL_TX_PIN_O && tx_busy)
        else $error("transmit did not start with a low start bit");

    a_tx_done_stop: assert property (
        tx_done_pulse |=> SERIAL_TX_PIN_O && status_reg[TX_DONE_BIT] && tx_busy)
        else $error("transmit done not aligned with stop bit start");

    a_rx_accept_load: assert property (
        rx_accept |=> status_reg[RX_DONE_BIT] && rx_buf_reg == $past(rx_char.data)
                      && rx_ninth_reg == $past(gate_bit))
        else $error("accepted character not loaded");

    a_overrun_keep: assert property (
        rx_valid && status_reg[RX_DONE_BIT] |=> $stable(rx_buf_reg) && $stable(rx_ninth_reg))
        else $error("overrun changed the receive buffer");

    a_mce_reject: assert property (
        s_rx_clean_reject |=> !status_reg[RX_DONE_BIT] && $stable(rx_buf_reg))
        else $error("ninth bit zero accepted under multiproc");

    a_rx_disabled: assert property (
        !ctrl_reg.rx_enable ##1 !ctrl_reg.rx_enable |-> !rx_valid)
        else $error("character received while disabled");

    a_flag_hold: assert property (
        status_reg[RX_DONE_BIT] && !clr_bits[RX_DONE_BIT] |=> status_reg[RX_DONE_BIT])
        else $error("receive flag cleared by hardware");

    a_irq_follow: assert property (
        rx_accept && mask_reg[RX_DONE_BIT] |=> IRQ_O [*2])
        else $error("interrupt missing for enabled receive flag");

    a_ack_single: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for more than one cycle");

    // sixteen clocks of a low line, one bit time at divider zero
    sequence s_bit_low;
        !SERIAL_TX_PIN_O [*8] ##1 !SERIAL_TX_PIN_O [*8];
    endsequence

    // start bit lasts a whole bit time
    a_start_len: assert property (
        s_tx_load && baud_reg == 16'h0000 && tick_reg |=> s_bit_low)
        else $error("start bit shorter than one bit time");

    // framing latched at the write fixes the busy length
    a_frame_len: assert property (
        $fell(tx_busy) && baud_reg == 16'h0000 |->
            tx_span_reg == (tx_nine_reg ? span_9 : span_8))
        else $error("transmit frame length wrong for the framing mode");

    // stop bit stays high
    a_stop_high: assert property (
        tx_done_pulse |-> SERIAL_TX_PIN_O [*8])
        else $error("stop bit not high");

    // enabled transmit flag raises the interrupt
    a_tx_irq: assert property (
        tx_done_pulse && mask_reg[TX_DONE_BIT] |=> IRQ_O)
        else $error("interrupt missing for enabled transmit flag");

    // 8-bit character with a zero stop bit is refused under multiproc
    a_stop_reject: assert property (
        rx_valid && !ctrl_reg.frame_mode_select && ctrl_reg.multiproc_enable
        && !rx_char.stop |=> !$rose(status_reg[RX_DONE_BIT]) && $stable(rx_ninth_reg))
        else $error("stop bit zero accepted under multiproc");

    // every request is answered in the next cycle
    a_ack_answer: assert property (
        bus_req && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered in the next cycle");

    // a status read returns the flags of the taking edge
    a_status_read: assert property (
        bus_req && !WB_ACK_O && !WB_WE_I && hit_status
        |=> WB_DAT_O == {30'h00000000, $past(status_reg)})
        else $error("status read returned the wrong flags");
endmodule

// >>> verilog/uart_mp_tx.sv
`timescale 1ns/1ps
module uart_mp_tx import uart_mp_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // timing and control
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic [7:0] data_i,
    input wire logic nine_i,
    input wire logic ninth_i,
    // line and status
    output logic tx_o,
    output logic busy_o,
    output logic done_o
);
    logic [9:0] shift_reg;
    logic [3:0] left_reg;
    logic [3:0] os_reg;
    logic busy_reg;
    logic tx_reg;
    logic done_reg;

    // a bit boundary falls every sixteenth baud tick
    wire boundary = busy_reg & tick_i & (os_reg == OS_LAST);
    wire [9:0] frame = nine_i ? {1'b1, ninth_i, data_i} : {2'b11, data_i};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= 10'h3FF;
            left_reg <= 4'h0;
            os_reg <= 4'h0;
            busy_reg <= 1'b0;
            tx_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start_i && !busy_reg) begin
                shift_reg <= frame;
                left_reg <= nine_i ? TX_BITS_9 : TX_BITS_8;
                os_reg <= 4'h0;
                busy_reg <= 1'b1;
                tx_reg <= 1'b0;
            end else if (busy_reg && tick_i) begin
                os_reg <= os_reg + 4'h1;
                if (boundary && left_reg == 4'h0) begin
                    busy_reg <= 1'b0;
                end else if (boundary) begin
                    tx_reg <= shift_reg[0];
                    shift_reg <= {1'b1, shift_reg[9:1]};
                    left_reg <= left_reg - 4'h1;
                    // done as the stop bit begins
                    done_reg <= (left_reg == TX_STOP_LEFT);
                end
            end
        end
    end

    assign tx_o = tx_reg;
    assign busy_o = busy_reg;
    assign done_o = done_reg;
endmodule
